// file: core/modem_status_flags_irq.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Reset command clears setup, tone, tx data, mode, mask and flag bits 0-3,5.
// - After reset command the normal bit is zero, so deep standby.
// - Reset command is the single address byte 01 with no data byte.
// - Writing setup bit 4 low enters standby, other registers kept.
// - Interrupt low when any sticky flag 0-3,5 set and its mask set.
// - Ring change flag sets on each edge of ring detect bit.
// - Standby powers down all but host interface and ring detector.
// - Reading status flags releases interrupt and clears bits 0-3,5.
// - Status bit 4 is live: selected energy or 2100 Hz detection.
// - Mask bit 4 set keeps interrupt low while that detection holds.
// - Status bit 6 follows the ring timer comparator output.
// - Bit 7 sets on a parity error while parity checking is enabled.
// - New received byte sets bit 2, and bit 3 if previous unread.
// - Bit 1 sets when transmit data is not reloaded in time.
module modem_status_flags_irq
  import modem_flags_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  // Decoded host bus transaction
  input wire logic bus_wr_i,
  input wire logic [7:0] bus_addr_i,
  input wire logic [7:0] bus_wdata_i,
  input wire logic bus_rd_i,
  output logic [7:0] bus_rdata_o,
  // Datapath events and levels
  input wire logic tx_ready_ev_i,
  input wire logic tx_underflow_ev_i,
  input wire logic rx_byte_ev_i,
  input wire logic [7:0] rx_byte_i,
  input wire logic parity_err_ev_i,
  input wire logic rx_energy_i,
  input wire logic tone_2100_i,
  input wire logic ring_timer_node_i,
  // Register contents for the datapath
  output logic [7:0] setup_o,
  output logic [7:0] tone_ctrl_o,
  output logic [7:0] tx_data_o,
  output logic [7:0] modulation_mode_reg_o,
  output logic datapath_enable_o,
  // Open-drain interrupt: output enable low while pulling low
  output logic interrupt_request_n_o,
  output logic interrupt_request_n_oe_n_o
);
  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [7:0] setup_r, setup_nxt;
  logic [7:0] tone_r, tone_nxt;
  logic [7:0] txd_r, txd_nxt;
  logic [7:0] mode_r, mode_nxt;
  logic [7:0] mask_r, mask_nxt;
  logic [7:0] rxb_r, rxb_nxt;
  logic [7:0] flags_r, flags_nxt;
  logic rx_unread_r, rx_unread_nxt;
  logic ring_prev_r, ring_prev_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic irq_oe_n_r, irq_oe_n_nxt;
  logic irq_level_n_r, irq_level_n_nxt;
  logic irq_req;
  logic reset_cmd, flags_read, live_det, running;

  assign reset_cmd = bus_wr_i && (bus_addr_i == ADDR_RESET_CMD);
  assign flags_read = bus_rd_i && (bus_addr_i == ADDR_STATUS_FLAGS);
  assign running = setup_r[SETUP_NORMAL_BIT];
  // Detector choice follows the tone register's detect select bit
  assign live_det = tone_r[TONE_SEL_2100_BIT] ? tone_2100_i : rx_energy_i;

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb
  begin
    setup_nxt = setup_r;
    tone_nxt = tone_r;
    txd_nxt = txd_r;
    mode_nxt = mode_r;
    mask_nxt = mask_r;
    rxb_nxt = rxb_r;
    flags_nxt = flags_r;
    rx_unread_nxt = rx_unread_r;
    rdata_nxt = rdata_r;
    ring_prev_nxt = ring_timer_node_i;
    // Clears first so that event sets below win
    if (flags_read)
    begin
      flags_nxt = flags_r & ~STICKY_MASK;
    end
    if (bus_rd_i && bus_addr_i == ADDR_RECEIVED_BYTE)
    begin
      rx_unread_nxt = 1'b0;
    end
    if (reset_cmd)
    begin
      setup_nxt = REG_RESET_VAL;
      tone_nxt = REG_RESET_VAL;
      txd_nxt = REG_RESET_VAL;
      mode_nxt = REG_RESET_VAL;
      mask_nxt = REG_RESET_VAL;
      flags_nxt = flags_r & ~STICKY_MASK;
    end
    else if (bus_wr_i)
    begin
      if (bus_addr_i == ADDR_SETUP)
      begin
        setup_nxt = bus_wdata_i;
      end
      else if (bus_addr_i == ADDR_TONE_CTRL)
      begin
        tone_nxt = bus_wdata_i;
      end
      else if (bus_addr_i == ADDR_TX_DATA)
      begin
        txd_nxt = bus_wdata_i;
      end
      else if (bus_addr_i == ADDR_MOD_MODE)
      begin
        mode_nxt = bus_wdata_i;
      end
      else if (bus_addr_i == ADDR_IRQ_MASK)
      begin
        mask_nxt = bus_wdata_i;
      end
    end
    // Datapath events are ignored in standby; ring sensing stays alive
    if (running)
    begin
      if (tx_ready_ev_i)
      begin
        flags_nxt[FLAG_TX_READY] = 1'b1;
      end
      if (tx_underflow_ev_i)
      begin
        flags_nxt[FLAG_TX_UNDERFLOW] = 1'b1;
      end
      if (rx_byte_ev_i)
      begin
        rxb_nxt = rx_byte_i;
        flags_nxt[FLAG_RX_READY] = 1'b1;
        if (rx_unread_r)
        begin
          flags_nxt[FLAG_RX_OVERFLOW] = 1'b1;
        end
        rx_unread_nxt = 1'b1;
      end
      // Parity flag is not sticky-cleared; it follows the next character
      if (rx_byte_ev_i)
      begin
        flags_nxt[FLAG_BAD_PARITY] = parity_err_ev_i && setup_r[SETUP_PARITY_EN_BIT];
      end
    end
    if (ring_timer_node_i != ring_prev_r)
    begin
      flags_nxt[FLAG_RING_CHANGE] = 1'b1;
    end
    flags_nxt[FLAG_RING_DETECT] = ring_timer_node_i;
    flags_nxt[FLAG_RX_DETECT] = running && live_det;
    if (bus_rd_i && bus_addr_i == ADDR_RECEIVED_BYTE)
    begin
      rdata_nxt = rxb_r;
    end
    else if (flags_read)
    begin
      rdata_nxt = flags_r;
    end
    else if (bus_rd_i)
    begin
      rdata_nxt = 8'h00;
    end
    // Read-clear lowers the request on the same edge as the flags
    irq_req = |(flags_nxt & mask_nxt & (STICKY_MASK | (8'h01 << FLAG_RX_DETECT)));
    // Both pin flops follow the request, so no gate sits after them
    irq_oe_n_nxt = ~irq_req;
    irq_level_n_nxt = ~irq_req;
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      setup_r <= REG_RESET_VAL;
      tone_r <= REG_RESET_VAL;
      txd_r <= REG_RESET_VAL;
      mode_r <= REG_RESET_VAL;
      mask_r <= REG_RESET_VAL;
      rxb_r <= REG_RESET_VAL;
      flags_r <= REG_RESET_VAL;
      rx_unread_r <= 1'b0;
      // Ring input idles low, so no false change follows reset
      ring_prev_r <= 1'b0;
      rdata_r <= REG_RESET_VAL;
      irq_oe_n_r <= 1'b1;
      irq_level_n_r <= 1'b1;
    end
    else if (clk_en_i)
    begin
      setup_r <= setup_nxt;
      tone_r <= tone_nxt;
      txd_r <= txd_nxt;
      mode_r <= mode_nxt;
      mask_r <= mask_nxt;
      rxb_r <= rxb_nxt;
      flags_r <= flags_nxt;
      rx_unread_r <= rx_unread_nxt;
      ring_prev_r <= ring_prev_nxt;
      rdata_r <= rdata_nxt;
      irq_oe_n_r <= irq_oe_n_nxt;
      irq_level_n_r <= irq_level_n_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign bus_rdata_o = rdata_r;
  assign setup_o = setup_r;
  assign tone_ctrl_o = tone_r;
  assign tx_data_o = txd_r;
  assign modulation_mode_reg_o = mode_r;
  assign datapath_enable_o = setup_r[SETUP_NORMAL_BIT];
  assign interrupt_request_n_o = irq_level_n_r;
  assign interrupt_request_n_oe_n_o = irq_oe_n_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_reset_cmd_clears: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (clk_en_i && reset_cmd) |=> (setup_r == 8'h00 && mask_r == 8'h00 && mode_r == 8'h00))
    else $error("reset command left a register set");
  a_reset_standby: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (clk_en_i && reset_cmd) |=> !datapath_enable_o)
    else $error("reset command did not enter standby");
  a_irq_tracks_flags: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (clk_en_i && !bus_wr_i && |(flags_r & mask_r & STICKY_MASK) && !flags_read
     && !$past(flags_read)) |=> !interrupt_request_n_oe_n_o)
    else $error("interrupt not asserted for masked flag");
  a_ring_edge_flag: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (clk_en_i && ring_timer_node_i != ring_prev_r && !reset_cmd) |=> flags_r[FLAG_RING_CHANGE])
    else $error("ring change flag missed");
  a_read_clears: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (clk_en_i && flags_read && !tx_ready_ev_i && !tx_underflow_ev_i && !rx_byte_ev_i
     && ring_timer_node_i == ring_prev_r) |=> (flags_r & STICKY_MASK) == 8'h00)
    else $error("status read did not clear sticky flags");
  a_live_detect: assert property (@(posedge core_clk_i) disable iff (rst_i)
    clk_en_i |=> flags_r[FLAG_RX_DETECT] == $past(running && live_det))
    else $error("live detect bit wrong");
  a_ring_level: assert property (@(posedge core_clk_i) disable iff (rst_i)
    clk_en_i |=> flags_r[FLAG_RING_DETECT] == $past(ring_timer_node_i))
    else $error("ring detect bit wrong");
  a_rx_overflow: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (clk_en_i && running && rx_byte_ev_i && rx_unread_r && !reset_cmd)
    |=> flags_r[FLAG_RX_OVERFLOW] && flags_r[FLAG_RX_READY])
    else $error("overflow not flagged");
  a_event_beats_clear: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (clk_en_i && running && flags_read && tx_underflow_ev_i) |=> flags_r[FLAG_TX_UNDERFLOW])
    else $error("event lost at read clear");
  a_reset_cmd_flags: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (clk_en_i && reset_cmd && !tx_ready_ev_i && !tx_underflow_ev_i && !rx_byte_ev_i
     && ring_timer_node_i == ring_prev_r)
    |=> ((flags_r & STICKY_MASK) == 8'h00 && tone_r == 8'h00 && txd_r == 8'h00))
    else $error("reset command left a flag or register set");
  a_setup_standby: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (clk_en_i && bus_wr_i && bus_addr_i == ADDR_SETUP && !bus_wdata_i[SETUP_NORMAL_BIT])
    |=> (!datapath_enable_o && $stable(tone_r) && $stable(txd_r) && $stable(mode_r)
     && $stable(mask_r)))
    else $error("standby write disturbed other registers");
  a_standby_quiet: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (clk_en_i && !running && !flags_r[FLAG_TX_READY])
    |=> (!flags_r[FLAG_TX_READY] && !flags_r[FLAG_RX_DETECT] && $stable(rxb_r)))
    else $error("datapath event taken in standby");
  a_ring_in_standby: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (clk_en_i && !running && ring_timer_node_i != ring_prev_r) |=> flags_r[FLAG_RING_CHANGE])
    else $error("ring change lost in standby");
  a_read_releases_pin: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (clk_en_i && flags_read && !bus_wr_i && !mask_r[FLAG_RX_DETECT] && !tx_ready_ev_i
     && !tx_underflow_ev_i && !rx_byte_ev_i && ring_timer_node_i == ring_prev_r)
    |=> (interrupt_request_n_oe_n_o && interrupt_request_n_o))
    else $error("status read did not release the interrupt");
  a_live_irq: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (mask_r[FLAG_RX_DETECT] && flags_r[FLAG_RX_DETECT]) |-> !interrupt_request_n_oe_n_o)
    else $error("live detect did not hold the interrupt");
  a_parity_flag: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (clk_en_i && running && rx_byte_ev_i)
    |=> flags_r[FLAG_BAD_PARITY] == $past(parity_err_ev_i && setup_r[SETUP_PARITY_EN_BIT]))
    else $error("parity flag wrong");
  a_rx_ready_flag: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (clk_en_i && running && rx_byte_ev_i)
    |=> (flags_r[FLAG_RX_READY] && rxb_r == $past(rx_byte_i)))
    else $error("received byte not flagged");
  a_underflow_flag: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (clk_en_i && running && tx_underflow_ev_i) |=> flags_r[FLAG_TX_UNDERFLOW])
    else $error("underflow not flagged");
  // Clock enable low must freeze every flag and the pin
  a_enable_freeze: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !clk_en_i |=> ($stable(flags_r) && $stable(interrupt_request_n_oe_n_o)))
    else $error("state moved while clock enable low");
endmodule : modem_status_flags_irq
`default_nettype wire

// file: include/modem_flags_pkg.sv
package modem_flags_pkg;
  // ----------------------------------------
  // Register addresses
  // ----------------------------------------
  localparam logic [7:0] ADDR_RESET_CMD = 8'h01;
  localparam logic [7:0] ADDR_SETUP = 8'he0;
  localparam logic [7:0] ADDR_TONE_CTRL = 8'he1;
  localparam logic [7:0] ADDR_TX_DATA = 8'he3;
  localparam logic [7:0] ADDR_MOD_MODE = 8'he7;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'hee;
  localparam logic [7:0] ADDR_RECEIVED_BYTE = 8'hea;
  localparam logic [7:0] ADDR_STATUS_FLAGS = 8'hef;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int FLAG_TX_READY = 0;
  localparam int FLAG_TX_UNDERFLOW = 1;
  localparam int FLAG_RX_READY = 2;
  localparam int FLAG_RX_OVERFLOW = 3;
  localparam int FLAG_RX_DETECT = 4;
  localparam int FLAG_RING_CHANGE = 5;
  localparam int FLAG_RING_DETECT = 6;
  localparam int FLAG_BAD_PARITY = 7;
  localparam int SETUP_NORMAL_BIT = 4;
  localparam int SETUP_PARITY_EN_BIT = 2;
  localparam int TONE_SEL_2100_BIT = 0;
  // Sticky bits that raise the interrupt and clear on read
  localparam logic [7:0] STICKY_MASK = 8'h2f;
  localparam logic [7:0] REG_RESET_VAL = 8'h00;
endpackage : modem_flags_pkg

// file: verif/host_model.sv
`timescale 1ns/1ps
`default_nettype none
// --------
// Host bus master
// --------
module host_model (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o
);
  initial {wr_o, rd_o, addr_o, wdata_o} = '0;
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
    output logic [7:0] q);
    @(posedge clk_i);
    wr_o <= w;
    rd_o <= !w;
    addr_o <= a;
    wdata_o <= d;
    @(posedge clk_i);
    wr_o <= 1'b0;
    rd_o <= 1'b0;
    // Released lines must not keep showing the last value
    addr_o <= ~a;
    wdata_o <= ~d;
    @(negedge clk_i);
    q = rdata_i;
  endtask : xfer
endmodule : host_model
`default_nettype wire

// file: verif/tb_modem_status_flags_irq.sv
`timescale 1ns/1ps
`default_nettype none
// --------
// Bench with reference flags model
// --------
module tb_modem_status_flags_irq;
  import modem_flags_pkg::*;
  logic clk = 0, rst = 1, wr, rd, txr = 0, txu = 0, rxe = 0, per = 0, en = 0, t21 = 0, ring = 0;
  logic cke = 1;
  logic [7:0] addr, wd, rdata, rxb = 0, setup, tone, txd, mode, q, exp_v;
  logic ien, oen, dpe;
  int bad_count = 0, checked = 0, cyc = 0, flg = 0, msk = 0, unr = 0, stb = 0, tsel = 0;
  int pen = 0, lastb = 0;
  modem_status_flags_irq u_modem_status_flags_irq (.core_clk_i(clk), .rst_i(rst),
    .clk_en_i(cke), .bus_wr_i(wr), .bus_addr_i(addr), .bus_wdata_i(wd), .bus_rd_i(rd),
    .bus_rdata_o(rdata), .tx_ready_ev_i(txr), .tx_underflow_ev_i(txu), .rx_byte_ev_i(rxe),
    .rx_byte_i(rxb), .parity_err_ev_i(per), .rx_energy_i(en), .tone_2100_i(t21),
    .ring_timer_node_i(ring), .setup_o(setup), .tone_ctrl_o(tone), .tx_data_o(txd),
    .modulation_mode_reg_o(mode), .datapath_enable_o(dpe), .interrupt_request_n_o(ien),
    .interrupt_request_n_oe_n_o(oen));
  host_model u_host_model (.clk_i(clk), .rdata_i(rdata), .wr_o(wr), .rd_o(rd),
    .addr_o(addr), .wdata_o(wd));
  always #5 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    // Ceiling well above the fewer than two hundred cycles the tests need
    if (cyc == 5000)
    begin
      bad_count++;
      finish_test();
    end
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  function automatic int live4();
    return int'(stb != 0 && (tsel != 0 ? t21 : en));
  endfunction : live4
  task automatic irq();
    logic [7:0] e;
    repeat (2) @(negedge clk);
    e = 8'(!((flg & msk & 'h2f) != 0 || (msk[4] && live4() != 0)));
    chk("irq_oe_n", e, {7'h0, oen});
    chk("irq_pin", e, {7'h0, ien});
  endtask : irq
  task automatic rdf();
    u_host_model.xfer(1'b0, ADDR_STATUS_FLAGS, 8'h00, q);
    chk("flags", 8'(flg | (ring << 6) | (live4() << 4)), q);
    flg = flg & 'hd0;
    irq();
  endtask : rdf
  task automatic wrr(input logic [7:0] a, input logic [7:0] d);
    u_host_model.xfer(1'b1, a, d, q);
    if (a == ADDR_SETUP) {stb, pen} = {31'h0, d[4], 31'h0, d[2]};
    if (a == ADDR_TONE_CTRL) tsel = int'(d[0]);
    if (a == ADDR_IRQ_MASK) msk = int'(d);
    if (a == ADDR_RESET_CMD) {flg, msk, stb, tsel, pen} = {flg & 'h80, 128'h0};
  endtask : wrr
  task automatic ev(input logic t, input logic u, input logic r, input logic p);
    lastb = int'($urandom) & 'hff;
    @(posedge clk);
    {txr, txu, rxe, per} <= {t, u, r, p};
    rxb <= 8'(lastb);
    @(posedge clk);
    {txr, txu, rxe, per} <= 4'h0;
    if (stb != 0) flg = flg | t | (u << 1) | (r ? 4 | (unr << 3) : 0);
    if (stb != 0 && r) {unr, flg[7]} = {32'h1, p && pen != 0};
  endtask : ev
  task automatic finish_test();
    $display("checked %0d bad %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  initial
  begin
    void'($urandom(32'hc5c432bb));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    ev(1, 1, 1, 0);
    rdf();
    $display("test standby done");
    wrr(ADDR_IRQ_MASK, 8'h2f);
    wrr(ADDR_SETUP, 8'h14);
    chk("setup", 8'h14, setup);
    ev(1, 0, 0, 0);
    irq();
    ev(0, 1, 0, 0);
    ev(0, 0, 1, 0);
    ev(0, 0, 1, 1);
    rdf();
    u_host_model.xfer(1'b0, ADDR_RECEIVED_BYTE, 8'h00, q);
    unr = 0;
    chk("rx_byte", 8'(lastb), q);
    ev(0, 0, 1, 0);
    rdf();
    $display("test flags done");
    wrr(ADDR_TONE_CTRL, 8'h41);
    wrr(ADDR_SETUP, 8'h00);
    chk("standby_tone", 8'h41, tone);
    chk("standby_enable", 8'h00, {7'h0, dpe});
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clk);
      ring <= !ring;
      repeat (20) @(posedge clk);
      flg = flg | 'h20;
      irq();
      rdf();
      rdf();
    end
    $display("test ring done");
    wrr(ADDR_TONE_CTRL, 8'h00);
    wrr(ADDR_SETUP, 8'h10);
    wrr(ADDR_IRQ_MASK, 8'h10);
    @(posedge clk);
    en <= 1'b1;
    irq();
    rdf();
    wrr(ADDR_TONE_CTRL, 8'h01);
    @(posedge clk);
    en <= 1'b0;
    t21 <= 1'b1;
    rdf();
    $display("test detect done");
    wrr(ADDR_IRQ_MASK, 8'h2f);
    exp_v = 8'(flg | (ring << 6) | (live4() << 4));
    fork
      u_host_model.xfer(1'b0, ADDR_STATUS_FLAGS, 8'h00, q);
      ev(1, 1, 0, 0);
    join
    chk("collide_flags", exp_v, q);
    flg = (flg & 'hd0) | 3;
    rdf();
    // Events while the clock enable is low must leave no trace
    @(posedge clk);
    cke <= 1'b0;
    ev(0, 1, 0, 0);
    @(posedge clk);
    cke <= 1'b1;
    flg = flg & 'hfd;
    rdf();
    $display("test collide done");
    exp_v = 8'($urandom);
    wrr(ADDR_TX_DATA, exp_v);
    chk("tx_data", exp_v, txd);
    exp_v = 8'($urandom) | 8'h01;
    wrr(ADDR_MOD_MODE, exp_v);
    chk("mode", exp_v, mode);
    ev(1, 0, 1, 0);
    wrr(ADDR_RESET_CMD, 8'($urandom));
    chk("reset_regs", 8'h00, setup | tone | txd | mode | {7'h0, dpe});
    rdf();
    $display("test reset done");
    finish_test();
  end
endmodule : tb_modem_status_flags_irq
`default_nettype wire
